// ---- rtl/lpc_top.sv ----
// Decided for this implementation: the AHB-Lite register port and the register offsets.
module lpc_top (
  input  wire logic                     mclk_i,
  input  wire logic                     srst_i,
  input  wire logic                     hsel_i,
  input  wire logic [31:0]              haddr_i,
  input  wire logic [1:0]               htrans_i,
  input  wire logic                     hwrite_i,
  input  wire logic [2:0]               hsize_i,
  input  wire logic [31:0]              hwdata_i,
  input  wire logic                     hready_i,
  output logic      [31:0]              hrdata_o,
  output logic                          hreadyout_o,
  output logic                          hresp_o,
  input  wire lpc_pkg::lpc_pix_in_type  pix_in_i,
  output lpc_pkg::lpc_pix_out_type      pix_out_o,
  output logic                          dark_set_user_o,
  output logic                          resp_set_user_o
);

  lpc_pkg::lpc_state_type st;
  lpc_pkg::lpc_state_type next_st;

  logic        dark_on;
  logic        resp_on;
  logic        gamma_on;
  logic [11:0] max_val;
  logic [11:0] gamma_sel;
  logic [11:0] gamma_pix;

  // ---------------------------------------------------------------------------
  // Derived controls
  // ---------------------------------------------------------------------------
  assign dark_on   = st.cfg.shade[lpc_pkg::LPC_SH_DK_EN_BIT]
                   & st.cfg.shade[lpc_pkg::LPC_SH_DK_AC_BIT];
  assign resp_on   = st.cfg.shade[lpc_pkg::LPC_SH_RS_EN_BIT]
                   & st.cfg.shade[lpc_pkg::LPC_SH_RS_AC_BIT];
  assign gamma_on  = st.cfg.gctrl[lpc_pkg::LPC_GC_EN_BIT];
  assign max_val   = st.cfg.depth12 ? lpc_pkg::LPC_MAX_12 : lpc_pkg::LPC_MAX_8;
  assign gamma_sel = st.cfg.gctrl[lpc_pkg::LPC_GC_USER_BIT] ? st.cfg.gamma_value
                   : lpc_pkg::LPC_GAMMA_ONE;

  lpc_gamma u_gamma (
    .pix_i   (st.s2.pix),
    .max_i   (max_val),
    .gamma_i (gamma_sel),
    .pix_o   (gamma_pix)
  );

  // ---------------------------------------------------------------------------
  // Register read mux
  // ---------------------------------------------------------------------------
  function automatic logic [31:0] lpc_read(input lpc_pkg::lpc_state_type s,
                                           input logic [7:0] a);
    logic [31:0] r;
    r = 32'h0000_0000;
    case (a)
      lpc_pkg::LPC_BIN_OFS:   r = {29'h0, s.cfg.horizontal_bin_factor};
      lpc_pkg::LPC_GCTRL_OFS: r = {30'h0, s.cfg.gctrl};
      lpc_pkg::LPC_GVAL_OFS:  r = {20'h0, s.cfg.gamma_value};
      lpc_pkg::LPC_SHADE_OFS: r = {26'h0, s.cfg.shade};
      lpc_pkg::LPC_DEPTH_OFS: r = {31'h0, s.cfg.depth12};
      lpc_pkg::LPC_STAT_OFS:  r = {s.in_cnt, s.out_cnt};
      default:                r = 32'h0000_0000;
    endcase
    return r;
  endfunction

  // ---------------------------------------------------------------------------
  // Next state
  // ---------------------------------------------------------------------------
  always_comb begin
    logic [27:0]        gprod;
    logic [15:0]        gval;
    logic signed [17:0] osum;
    logic [11:0]        shaded;
    logic [2:0]         cnt_n;
    logic [13:0]        acc;
    logic               start;
    gprod   = 28'h0;
    gval    = 16'h0;
    osum    = 18'sh0;
    shaded  = 12'h000;
    cnt_n   = 3'h0;
    acc     = 14'h0;
    start   = 1'b0;
    next_st = st;

    // AHB data phase write
    if (st.wr_pend) begin
      case (st.wr_addr)
        lpc_pkg::LPC_BIN_OFS: begin
          if (hwdata_i[2:0] >= lpc_pkg::LPC_BIN_MIN && hwdata_i[2:0] <= lpc_pkg::LPC_BIN_MAX
              && hwdata_i[31:3] == 29'h0) begin
            next_st.cfg.horizontal_bin_factor = hwdata_i[2:0];
          end
        end
        lpc_pkg::LPC_GCTRL_OFS: next_st.cfg.gctrl       = hwdata_i[1:0];
        lpc_pkg::LPC_GVAL_OFS:  next_st.cfg.gamma_value = hwdata_i[11:0];
        lpc_pkg::LPC_SHADE_OFS: next_st.cfg.shade       = hwdata_i[5:0];
        lpc_pkg::LPC_DEPTH_OFS: next_st.cfg.depth12     = hwdata_i[lpc_pkg::LPC_DEPTH_BIT];
        default: begin
        end
      endcase
    end

    // AHB address phase
    next_st.wr_pend   = 1'b0;
    next_st.hreadyout = 1'b1;
    if (hsel_i && htrans_i[1] && hready_i) begin
      next_st.wr_pend = hwrite_i;
      next_st.wr_addr = haddr_i[7:0];
      if (!hwrite_i) begin
        next_st.hrdata = lpc_read(next_st, haddr_i[7:0]);
      end
    end

    // Shading stage
    gval = {4'h0, pix_in_i.pix};
    if (resp_on) begin
      gprod = 28'(pix_in_i.pix) * 28'(pix_in_i.gain);
      gval  = gprod[27:lpc_pkg::LPC_GAIN_FRAC];
    end
    osum = 18'(signed'({2'b00, gval}));
    if (dark_on) begin
      osum = osum + 18'(pix_in_i.offset);
    end
    if (osum < 18'sh0) begin
      shaded = 12'h000;
    end else if (osum > 18'(signed'({6'h00, max_val}))) begin
      shaded = max_val;
    end else begin
      shaded = osum[11:0];
    end
    next_st.s1.valid      = pix_in_i.valid;
    next_st.s1.line_start = pix_in_i.line_start;
    if (pix_in_i.valid) begin
      next_st.s1.pix = shaded;
      next_st.in_cnt = pix_in_i.line_start ? 16'h0001 : st.in_cnt + 16'h0001;
    end

    // Binning stage
    next_st.s2.valid      = 1'b0;
    next_st.s2.line_start = 1'b0;
    if (st.s1.valid) begin
      if (st.cfg.horizontal_bin_factor == lpc_pkg::LPC_BIN_MIN) begin
        next_st.s2     = st.s1;
        next_st.bin_cnt = 3'h0;
      end else begin
        start = st.s1.line_start || st.bin_cnt == 3'h0;
        acc   = (start ? 14'h0 : st.bin_sum) + {2'h0, st.s1.pix};
        cnt_n = (start ? 3'h0 : st.bin_cnt) + 3'h1;
        if (start) begin
          next_st.bin_ls = st.s1.line_start;
        end
        if (cnt_n >= st.cfg.horizontal_bin_factor) begin
          next_st.s2.valid      = 1'b1;
          next_st.s2.line_start = start ? st.s1.line_start : st.bin_ls;
          next_st.s2.pix        = (acc > {2'h0, max_val}) ? max_val : acc[11:0];
          next_st.bin_cnt       = 3'h0;
        end else begin
          next_st.bin_cnt = cnt_n;
          next_st.bin_sum = acc;
        end
      end
    end

    // Gamma stage
    next_st.out.valid      = st.s2.valid;
    next_st.out.line_start = st.s2.line_start;
    if (st.s2.valid) begin
      next_st.out.pix = gamma_on ? gamma_pix : st.s2.pix;
      next_st.out_cnt = st.s2.line_start ? 16'h0001 : st.out_cnt + 16'h0001;
    end
  end

  // ---------------------------------------------------------------------------
  // State register
  // ---------------------------------------------------------------------------
  always_ff @(posedge mclk_i) begin
    if (srst_i) begin
      st                           <= '0;
      st.cfg.horizontal_bin_factor <= lpc_pkg::LPC_BIN_RST;
      st.cfg.gctrl                 <= lpc_pkg::LPC_GCTRL_RST;
      st.cfg.gamma_value           <= lpc_pkg::LPC_GVAL_RST;
      st.cfg.shade                 <= lpc_pkg::LPC_SHADE_RST;
      st.cfg.depth12               <= lpc_pkg::LPC_DEPTH_RST;
      st.hreadyout                 <= 1'b1;
    end else begin
      st <= next_st;
    end
  end

  // ---------------------------------------------------------------------------
  // Outputs
  // ---------------------------------------------------------------------------
  assign hrdata_o        = st.hrdata;
  assign hreadyout_o     = st.hreadyout;
  assign hresp_o         = 1'b0;
  assign pix_out_o       = st.out;
  assign dark_set_user_o = st.cfg.shade[lpc_pkg::LPC_SH_DK_US_BIT];
  assign resp_set_user_o = st.cfg.shade[lpc_pkg::LPC_SH_RS_US_BIT];

  // ---------------------------------------------------------------------------
  // Assertions
  // ---------------------------------------------------------------------------
  property p_bin_range;
    @(posedge mclk_i) disable iff (srst_i)
    st.cfg.horizontal_bin_factor >= lpc_pkg::LPC_BIN_MIN
    && st.cfg.horizontal_bin_factor <= lpc_pkg::LPC_BIN_MAX;
  endproperty
  a_bin_range: assert property (p_bin_range) else $error("bin factor out of range");

  property p_bin_off;
    @(posedge mclk_i) disable iff (srst_i)
    (st.s1.valid && st.cfg.horizontal_bin_factor == 3'h1) |=>
      (st.s2.valid && st.s2.pix == $past(st.s1.pix));
  endproperty
  a_bin_off: assert property (p_bin_off) else $error("binning off changed pixel");

  property p_bin_two;
    @(posedge mclk_i) disable iff (srst_i)
    (st.cfg.horizontal_bin_factor == 3'h2 && st.s1.valid && st.s1.line_start ##1
     st.s1.valid && !st.s1.line_start && $stable(st.cfg)) |=>
      (st.s2.valid && st.s2.pix == ((({2'h0, $past(st.s1.pix, 2)} + {2'h0, $past(st.s1.pix)})
       > {2'h0, max_val}) ? max_val : 12'($past(st.s1.pix, 2) + $past(st.s1.pix))));
  endproperty
  a_bin_two: assert property (p_bin_two) else $error("pair sum wrong");

  property p_bin_gap;
    @(posedge mclk_i) disable iff (srst_i)
    (st.cfg.horizontal_bin_factor == 3'h3 && st.s1.valid && st.s1.line_start) |=>
      !st.s2.valid ##1 !st.s2.valid;
  endproperty
  a_bin_gap: assert property (p_bin_gap) else $error("early binned output");

  property p_clip;
    @(posedge mclk_i) disable iff (srst_i)
    st.s1.valid |-> st.s1.pix <= max_val;
  endproperty
  a_clip: assert property (p_clip) else $error("shaded pixel above full scale");

  property p_gamma_off;
    @(posedge mclk_i) disable iff (srst_i)
    (st.s2.valid && !gamma_on) |=> st.out.pix == $past(st.s2.pix);
  endproperty
  a_gamma_off: assert property (p_gamma_off) else $error("gamma applied while off");

  property p_gamma_ends;
    @(posedge mclk_i) disable iff (srst_i)
    (st.s2.valid && gamma_on && (st.s2.pix == 12'h000 || st.s2.pix == max_val)) |=>
      st.out.pix == $past(st.s2.pix);
  endproperty
  a_gamma_ends: assert property (p_gamma_ends) else $error("gamma moved an end point");

  property p_gamma_one;
    @(posedge mclk_i) disable iff (srst_i)
    (st.s2.valid && gamma_on && gamma_sel == lpc_pkg::LPC_GAMMA_ONE) |=>
      st.out.pix == $past(st.s2.pix);
  endproperty
  a_gamma_one: assert property (p_gamma_one) else $error("unity gamma changed pixel");

  property p_shade_idle;
    @(posedge mclk_i) disable iff (srst_i)
    (pix_in_i.valid && !dark_on && !resp_on) |=>
      st.s1.pix == (($past(pix_in_i.pix) > max_val) ? max_val : $past(pix_in_i.pix));
  endproperty
  a_shade_idle: assert property (p_shade_idle) else $error("shading without active set");

  property p_dark_only;
    @(posedge mclk_i) disable iff (srst_i)
    (pix_in_i.valid && dark_on && !resp_on && pix_in_i.offset >= 12'sh000) |=>
      st.s1.pix >= (($past(pix_in_i.pix) > max_val) ? max_val : $past(pix_in_i.pix));
  endproperty
  a_dark_only: assert property (p_dark_only) else $error("offset lowered pixel");

  property p_out_follows;
    @(posedge mclk_i) disable iff (srst_i)
    st.s2.valid |=> st.out.valid && st.out.line_start == $past(st.s2.line_start);
  endproperty
  a_out_follows: assert property (p_out_follows) else $error("pixel lost");

  property p_out_quiet;
    @(posedge mclk_i) disable iff (srst_i)
    !st.s2.valid |=> !st.out.valid;
  endproperty
  a_out_quiet: assert property (p_out_quiet) else $error("spurious output pixel");

  property p_bin_first;
    @(posedge mclk_i) disable iff (srst_i)
    (st.s1.valid && st.s1.line_start
     && st.cfg.horizontal_bin_factor != lpc_pkg::LPC_BIN_MIN) |=> !st.s2.valid;
  endproperty
  a_bin_first: assert property (p_bin_first) else $error("lone pixel binned");

  property p_bin_off_start;
    @(posedge mclk_i) disable iff (srst_i)
    (st.s1.valid && st.cfg.horizontal_bin_factor == lpc_pkg::LPC_BIN_MIN) |=>
      st.s2.line_start == $past(st.s1.line_start);
  endproperty
  a_bin_off_start: assert property (p_bin_off_start) else $error("line start lost");

  property p_out_scale;
    @(posedge mclk_i) disable iff (srst_i)
    st.out.valid |-> st.out.pix <= max_val;
  endproperty
  a_out_scale: assert property (p_out_scale) else $error("output above full scale");

  property p_resp_only;
    @(posedge mclk_i) disable iff (srst_i)
    (pix_in_i.valid && resp_on && !dark_on && pix_in_i.gain >= 16'h1000) |=>
      st.s1.pix >= (($past(pix_in_i.pix) > max_val) ? max_val : $past(pix_in_i.pix));
  endproperty
  a_resp_only: assert property (p_resp_only) else $error("gain lowered pixel");

  property p_in_count;
    @(posedge mclk_i) disable iff (srst_i)
    (pix_in_i.valid && pix_in_i.line_start) |=> st.in_cnt == 16'h0001;
  endproperty
  a_in_count: assert property (p_in_count) else $error("input count not restarted");

  property p_out_count;
    @(posedge mclk_i) disable iff (srst_i)
    (st.s2.valid && st.s2.line_start) |=> st.out_cnt == 16'h0001;
  endproperty
  a_out_count: assert property (p_out_count) else $error("output count not restarted");

endmodule

// ---- rtl/lpc_pkg.sv ----
package lpc_pkg;

  // ---------------------------------------------------------------------------
  // Register offsets
  // ---------------------------------------------------------------------------
  localparam logic [7:0]  LPC_BIN_OFS    = 8'h00;
  localparam logic [7:0]  LPC_GCTRL_OFS  = 8'h04;
  localparam logic [7:0]  LPC_GVAL_OFS   = 8'h08;
  localparam logic [7:0]  LPC_SHADE_OFS  = 8'h0c;
  localparam logic [7:0]  LPC_DEPTH_OFS  = 8'h10;
  localparam logic [7:0]  LPC_STAT_OFS   = 8'h14;

  // ---------------------------------------------------------------------------
  // Field positions
  // ---------------------------------------------------------------------------
  localparam int          LPC_GC_EN_BIT    = 0;
  localparam int          LPC_GC_USER_BIT  = 1;
  localparam int          LPC_SH_DK_EN_BIT = 0;
  localparam int          LPC_SH_RS_EN_BIT = 1;
  localparam int          LPC_SH_DK_AC_BIT = 2;
  localparam int          LPC_SH_RS_AC_BIT = 3;
  localparam int          LPC_SH_DK_US_BIT = 4;
  localparam int          LPC_SH_RS_US_BIT = 5;
  localparam int          LPC_DEPTH_BIT    = 0;
  localparam int          LPC_GAIN_FRAC    = 12;
  localparam int          LPC_GAMMA_FRAC   = 10;

  // ---------------------------------------------------------------------------
  // Values after reset and fixed values
  // ---------------------------------------------------------------------------
  localparam logic [2:0]  LPC_BIN_RST    = 3'h1;
  localparam logic [2:0]  LPC_BIN_MIN    = 3'h1;
  localparam logic [2:0]  LPC_BIN_MAX    = 3'h4;
  localparam logic [11:0] LPC_GAMMA_ONE  = 12'h400;
  localparam logic [11:0] LPC_GVAL_RST   = 12'h400;
  localparam logic [11:0] LPC_MAX_8      = 12'h0ff;
  localparam logic [11:0] LPC_MAX_12     = 12'hfff;
  localparam logic        LPC_DEPTH_RST  = 1'b1;
  localparam logic [1:0]  LPC_GCTRL_RST  = 2'h0;
  localparam logic [5:0]  LPC_SHADE_RST  = 6'h00;

  // ---------------------------------------------------------------------------
  // Carriers
  // ---------------------------------------------------------------------------
  typedef struct packed {
    logic               valid;
    logic               line_start;
    logic [11:0]        pix;
    logic signed [11:0] offset;
    logic [15:0]        gain;
  } lpc_pix_in_type;

  typedef struct packed {
    logic        valid;
    logic        line_start;
    logic [11:0] pix;
  } lpc_pix_out_type;

  typedef struct packed {
    logic [2:0]  horizontal_bin_factor;
    logic [1:0]  gctrl;
    logic [11:0] gamma_value;
    logic [5:0]  shade;
    logic        depth12;
  } lpc_cfg_type;

  typedef struct packed {
    lpc_cfg_type     cfg;
    logic            wr_pend;
    logic [7:0]      wr_addr;
    logic [31:0]     hrdata;
    logic            hreadyout;
    lpc_pix_out_type s1;
    logic [2:0]      bin_cnt;
    logic [13:0]     bin_sum;
    logic            bin_ls;
    lpc_pix_out_type s2;
    lpc_pix_out_type out;
    logic [15:0]     in_cnt;
    logic [15:0]     out_cnt;
  } lpc_state_type;

endpackage

// ---- rtl/lpc_gamma.sv ----
module lpc_gamma (
  input  wire logic [11:0] pix_i,
  input  wire logic [11:0] max_i,
  input  wire logic [11:0] gamma_i,
  output logic      [11:0] pix_o
);

  // ---------------------------------------------------------------------------
  // Log2 approximation, 4.10 fixed point
  // ---------------------------------------------------------------------------
  function automatic logic [13:0] lpc_log2(input logic [11:0] v);
    logic [3:0]  p;
    logic [11:0] sh;
    p = 4'h0;
    for (int i = 0; i < 12; i++) begin
      if (v[i]) begin
        p = 4'(i);
      end
    end
    sh = v << (4'hb - p);
    return {p, sh[10:1]};
  endfunction

  logic [11:0] x;
  logic [13:0] d;
  logic [25:0] prod;
  logic [15:0] t;
  logic [11:0] m;
  logic [23:0] scaled;
  logic [11:0] res;

  // ---------------------------------------------------------------------------
  // Power curve through exp2(-gamma * log2(max / x))
  // ---------------------------------------------------------------------------
  always_comb begin
    x      = (pix_i > max_i) ? max_i : pix_i;
    d      = lpc_log2(max_i) - lpc_log2(x);
    prod   = 26'(d) * 26'(gamma_i);
    t      = prod[25:10];
    m      = 12'h800 - {2'h0, t[9:0]};
    scaled = 24'(max_i) * 24'(m);
    res    = 12'((scaled >> 11) >> t[15:10]);
    if (t[15:10] >= 6'h0c) begin
      res = 12'h000;
    end
    if (gamma_i == lpc_pkg::LPC_GAMMA_ONE) begin
      pix_o = x;
    end else if (x == 12'h000 || x == max_i) begin
      pix_o = x;
    end else begin
      pix_o = res;
    end
  end

endmodule

// ---- testbench/lpc_sensor_model.sv ----
module lpc_sensor_model (
  input  wire logic                    mclk_i,
  input  wire logic                    srst_i,
  input  wire logic                    go_i,
  input  wire logic [7:0]              count_i,
  input  wire logic [11:0]             pix_v_i,
  input  wire logic signed [11:0]      off_i,
  input  wire logic [15:0]             gain_i,
  output lpc_pkg::lpc_pix_in_type      pix_in_o,
  output logic                         busy_o
);
  timeunit 1ns;
  timeprecision 1ns;

  logic [7:0] left;

  assign busy_o = (left != 8'h00);

  // ---------------------------------------------------------------------------
  // Line readout with per-pixel coefficients
  // ---------------------------------------------------------------------------
  always @(posedge mclk_i) begin
    if (srst_i) begin
      left     <= 8'h00;
      pix_in_o <= '0;
    end else begin
      if (left != 8'h00) begin
        pix_in_o.valid      <= 1'b1;
        pix_in_o.line_start <= (left == count_i);
        pix_in_o.pix        <= pix_v_i;
        pix_in_o.offset     <= off_i;
        pix_in_o.gain       <= gain_i;
        left                <= left - 8'h01;
      end else begin
        pix_in_o.valid      <= 1'b0;
        pix_in_o.line_start <= 1'b0;
        pix_in_o.pix        <= ~pix_in_o.pix;
        pix_in_o.offset     <= ~pix_in_o.offset;
        pix_in_o.gain       <= ~pix_in_o.gain;
      end
      if (go_i) begin
        left <= count_i;
      end
    end
  end
endmodule

// ---- testbench/tb_top.sv ----
module tb_top;
  timeunit 1ns;
  timeprecision 1ns;

  logic                      mclk_i, srst_i, hsel_i, hwrite_i, go, busy;
  logic [31:0]               haddr_i, hwdata_i, hrdata_o, rd;
  logic [1:0]                htrans_i;
  logic [2:0]                hsize_i;
  logic                      hreadyout_o, hresp_o, dark_set_user_o, resp_set_user_o;
  logic [7:0]                cnt;
  logic [11:0]               pv;
  logic signed [11:0]        ov;
  logic [15:0]               gv;
  lpc_pkg::lpc_pix_in_type   pix_in;
  lpc_pkg::lpc_pix_out_type  pix_out;
  lpc_pkg::lpc_pix_out_type  cap[$];
  int                        err_count, n_tests, cycles;

  lpc_top u_lpc_top (
    .mclk_i(mclk_i), .srst_i(srst_i), .hsel_i(hsel_i), .haddr_i(haddr_i),
    .htrans_i(htrans_i), .hwrite_i(hwrite_i), .hsize_i(hsize_i), .hwdata_i(hwdata_i),
    .hready_i(hreadyout_o), .hrdata_o(hrdata_o), .hreadyout_o(hreadyout_o),
    .hresp_o(hresp_o), .pix_in_i(pix_in), .pix_out_o(pix_out),
    .dark_set_user_o(dark_set_user_o), .resp_set_user_o(resp_set_user_o)
  );

  lpc_sensor_model u_lpc_sensor_model (
    .mclk_i(mclk_i), .srst_i(srst_i), .go_i(go), .count_i(cnt), .pix_v_i(pv),
    .off_i(ov), .gain_i(gv), .pix_in_o(pix_in), .busy_o(busy)
  );

  // ---------------------------------------------------------------------------
  // Clock, timeout and output capture
  // ---------------------------------------------------------------------------
  initial begin
    mclk_i = 1'b0;
    forever #50 mclk_i = ~mclk_i;
  end

  always @(posedge mclk_i) begin
    cycles++;
    if (cycles == 20000) begin
      err_count++;
      $display("mismatch at %0t: run timed out", $time);
      close_out();
    end
    if (pix_out.valid === 1'b1) begin
      cap.push_back(pix_out);
    end
  end

  // ---------------------------------------------------------------------------
  // Tasks
  // ---------------------------------------------------------------------------
  task automatic close_out();
    $display("tests %0d errors %0d", n_tests, err_count);
    if (err_count == 0 && n_tests > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
    n_tests++;
    if (got !== exp) begin
      err_count++;
      $display("mismatch at %0t: %s got %h exp %h", $time, what, got, exp);
    end
  endtask

  task automatic ahb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    hsel_i   <= 1'b1;
    htrans_i <= 2'b10;
    haddr_i  <= {24'h000000, a};
    hwrite_i <= wr;
    hsize_i  <= 3'b010;
    do begin
      @(posedge mclk_i);
    end while (hreadyout_o !== 1'b1);
    hsel_i   <= 1'b0;
    htrans_i <= 2'b00;
    hwdata_i <= d;
    do begin
      @(posedge mclk_i);
    end while (hreadyout_o !== 1'b1);
    rd = hrdata_o;
    chk({31'h0, hresp_o}, 32'h0, "response");
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    ahb(1'b1, a, d);
  endtask

  task automatic rdc(input logic [7:0] a, input logic [31:0] exp);
    ahb(1'b0, a, 32'h0);
    chk(rd, exp, "register");
  endtask

  task automatic line(input logic [7:0] n, input logic [11:0] p, input logic [11:0] o,
                      input logic [15:0] g, input int en, input logic [11:0] ep, input bit pc);
    int k;
    cap.delete();
    cnt <= n;
    pv  <= p;
    ov  <= o;
    gv  <= g;
    go  <= 1'b1;
    @(posedge mclk_i);
    go  <= 1'b0;
    k = 0;
    do begin
      @(posedge mclk_i);
      k++;
    end while (busy === 1'b1 && k < 300);
    repeat (6) @(posedge mclk_i);
    chk(32'(cap.size()), 32'(en), "pixel count");
    if (cap.size() > 0) begin
      chk({31'h0, cap[0].line_start}, 32'h1, "line start");
    end
    foreach (cap[i]) begin
      if (pc) begin
        chk({20'h0, cap[i].pix}, {20'h0, ep}, "pixel");
      end
    end
  endtask

  // ---------------------------------------------------------------------------
  // Main sequence
  // ---------------------------------------------------------------------------
  initial begin
    srst_i = 1'b1;    hsel_i = 1'b0;     htrans_i = 2'b00;  haddr_i = 32'h0;
    hwrite_i = 1'b0;  hsize_i = 3'b010;  hwdata_i = 32'h0;  go = 1'b0;
    cnt = 8'h00;      pv = 12'h000;      ov = 12'h000;      gv = 16'h1000;
    err_count = 0;    n_tests = 0;       cycles = 0;
    repeat (8) @(posedge mclk_i);
    srst_i <= 1'b0;
    @(posedge mclk_i);
    rdc(8'h00, 32'h1);
    rdc(8'h04, 32'h0);
    rdc(8'h08, 32'h400);
    rdc(8'h0c, 32'h0);
    rdc(8'h10, 32'h1);
    rdc(8'h20, 32'h0);
    wr(8'h00, 32'h5);
    rdc(8'h00, 32'h1);
    wr(8'h00, 32'h0);
    rdc(8'h00, 32'h1);
    line(8'd4, 12'h123, 12'h0, 16'h1000, 4, 12'h123, 1);
    for (int b = 2; b <= 4; b++) begin
      wr(8'h00, 32'(b));
      rdc(8'h00, 32'(b));
      line(8'd12, 12'h100, 12'h0, 16'h1000, 12 / b, 12'(b * 256), 1);
      rdc(8'h14, {16'h000c, 16'(12 / b)});
    end
    line(8'd6, 12'h100, 12'h0, 16'h1000, 1, 12'h400, 1);
    line(8'd4, 12'h500, 12'h0, 16'h1000, 1, 12'hfff, 1);
    wr(8'h00, 32'h1);
    wr(8'h0c, 32'h01);
    line(8'd2, 12'h100, 12'h010, 16'h2000, 2, 12'h100, 1);
    wr(8'h0c, 32'h02);
    line(8'd2, 12'h100, 12'h010, 16'h2000, 2, 12'h100, 1);
    wr(8'h0c, 32'h05);
    line(8'd2, 12'h100, 12'h010, 16'h2000, 2, 12'h110, 1);
    wr(8'h0c, 32'h0a);
    line(8'd2, 12'h100, 12'h010, 16'h2000, 2, 12'h200, 1);
    wr(8'h0c, 32'h0f);
    line(8'd2, 12'h100, 12'h010, 16'h2000, 2, 12'h210, 1);
    line(8'd2, 12'h010, 12'hfe0, 16'h1000, 2, 12'h000, 1);
    line(8'd2, 12'h800, 12'h000, 16'hf000, 2, 12'hfff, 1);
    wr(8'h0c, 32'h3f);
    @(posedge mclk_i);
    chk({31'h0, dark_set_user_o}, 32'h1, "dark set source");
    chk({31'h0, resp_set_user_o}, 32'h1, "response set source");
    wr(8'h0c, 32'h00);
    wr(8'h04, 32'h1);
    wr(8'h04, 32'h3);
    wr(8'h08, 32'h800);
    rdc(8'h08, 32'h800);
    line(8'd2, 12'h000, 12'h0, 16'h1000, 2, 12'h000, 1);
    line(8'd2, 12'hfff, 12'h0, 16'h1000, 2, 12'hfff, 1);
    line(8'd1, 12'h800, 12'h0, 16'h1000, 1, 12'h000, 0);
    chk({31'h0, cap[0].pix < 12'h800}, 32'h1, "gamma above one darkens");
    wr(8'h08, 32'h200);
    line(8'd1, 12'h400, 12'h0, 16'h1000, 1, 12'h000, 0);
    chk({31'h0, cap[0].pix > 12'h400}, 32'h1, "gamma below one brightens");
    wr(8'h08, 32'h400);
    line(8'd2, 12'h321, 12'h0, 16'h1000, 2, 12'h321, 1);
    wr(8'h08, 32'h800);
    wr(8'h04, 32'h0);
    line(8'd2, 12'h321, 12'h0, 16'h1000, 2, 12'h321, 1);
    wr(8'h04, 32'h1);
    line(8'd2, 12'h321, 12'h0, 16'h1000, 2, 12'h321, 1);
    wr(8'h04, 32'h3);
    wr(8'h10, 32'h0);
    rdc(8'h10, 32'h0);
    line(8'd2, 12'h0ff, 12'h0, 16'h1000, 2, 12'h0ff, 1);
    line(8'd2, 12'h300, 12'h0, 16'h1000, 2, 12'h0ff, 1);
    line(8'd1, 12'h080, 12'h0, 16'h1000, 1, 12'h000, 0);
    chk({31'h0, cap[0].pix < 12'h080}, 32'h1, "gamma on 8-bit scale");
    wr(8'h08, 32'hfff);
    rdc(8'h08, 32'hfff);
    wr(8'h08, 32'h0);
    rdc(8'h08, 32'h0);
    line(8'd1, 12'h080, 12'h0, 16'h1000, 1, 12'h0ff, 1);
    close_out();
  end
endmodule
